// file: logic/status_filter_map.vh
`ifndef STATUS_FILTER_MAP_VH
`define STATUS_FILTER_MAP_VH

// register select codes on the command port
`define SEL_OPERATION_COND 4'h0
`define SEL_OPERATION_EVENT 4'h1
`define SEL_OPERATION_ENABLE 4'h2
`define SEL_OPERATION_FALL 4'h3
`define SEL_OPERATION_RISE 4'h4
`define SEL_QUESTIONABLE_COND 4'h5
`define SEL_QUESTIONABLE_EVENT 4'h6
`define SEL_QUESTIONABLE_ENABLE 4'h7
`define SEL_QUESTIONABLE_FALL 4'h8
`define SEL_QUESTIONABLE_RISE 4'h9

// register width and the legal value range 0..32767
`define STATUS_WIDTH 16
`define VALUE_MASK 16'h7fff

// reset and preset values
`define RST_ENABLE 16'h0000
`define RST_FALL_FILTER 16'h0000
`define RST_RISE_FILTER 16'h7fff
`define RST_EVENT 16'h0000

// operation condition bit positions
`define OP_BIT_ALIGN 0
`define OP_BIT_SWEEP 3
`define OP_BIT_MEASURE 4
`define OP_BIT_TRIG_WAIT 5
`define OP_BIT_PAUSED 8

// questionable condition bit positions
`define QU_BIT_POWER 3
`define QU_BIT_WARMUP 4
`define QU_BIT_FREQ 5
`define QU_BIT_ALIGN_FAULT 8
`define QU_BIT_INTEGRITY 9

`endif

// file: logic/cond_sync.v
`timescale 1ns/100ps
module cond_sync #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // cond_sync

// file: logic/status_group.v
`timescale 1ns/100ps
`include "status_filter_map.vh"
module status_group (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // synchronised live conditions
  input wire [`STATUS_WIDTH-1:0] cond,
  // filters and enable mask
  input wire [`STATUS_WIDTH-1:0] rise_filter,
  input wire [`STATUS_WIDTH-1:0] fall_filter,
  input wire [`STATUS_WIDTH-1:0] enable_mask,
  // read of the event register, clears it
  input wire event_read,
  // latched events and summary bit
  output reg [`STATUS_WIDTH-1:0] event_reg,
  output reg summary_reg
);

  reg [`STATUS_WIDTH-1:0] cond_prev_reg;
  wire [`STATUS_WIDTH-1:0] rose;
  wire [`STATUS_WIDTH-1:0] fell;
  wire [`STATUS_WIDTH-1:0] event_set;
  wire [`STATUS_WIDTH-1:0] event_next;

  assign rose = cond & ~cond_prev_reg;
  assign fell = ~cond & cond_prev_reg;
  // an edge is recorded only where its filter bit selects it
  assign event_set = (rose & rise_filter) | (fell & fall_filter); // [R3] [R5] [R6]
  // a new edge in the read cycle survives the clear
  assign event_next = (event_read ? `RST_EVENT : event_reg) | event_set; // [R4]

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cond_prev_reg <= {`STATUS_WIDTH{1'b0}};
      event_reg <= `RST_EVENT;
      summary_reg <= 1'b0;
    end else begin
      cond_prev_reg <= cond;
      event_reg <= event_next; // [R4]
      summary_reg <= |(event_reg & enable_mask); // [R17]
    end
  end

endmodule // status_group

// file: logic/scpi_status_event_filter.v
// Functional notes
// R1: operation summary is status byte bit 7 from enabled events; mask 0..32767.
// R2: operation enable mask clears to zero at preset.
// R3: event bit sets only when the filter selects the observed condition edge.
// R4: event bits hold until read; read returns value then clears register.
// R5: falling condition with fall filter bit set sets event; fall filter resets zero.
// R6: rising condition with rise filter bit set sets event; rise filter resets 32767.
// R7: alignment activity maps to operation bit 0.
// R8: preset restores filters, enable masks and queue enable.
// R9: preset leaves event registers, queue and other enable masks untouched.
// R10: questionable condition reads live, unlatched; zero at preset (preset does not touch it here; it follows the synchronised inputs).
// R11: questionable summary is status byte bit 3 from enabled events.
// R12: questionable enable mask clears to zero at preset.
// R13: masks and filters exchange as integer sums of bit weights.
// R14: controller should check bit 3 after each measurement.
// R15: operation bits: 0 align, 3 sweep, 4 measure, 5 trigger wait, 8 paused.
// R16: questionable bits: 3 power, 4 warmup, 5 frequency, 8 align fault, 9 integrity.
// R17: summary is OR of event AND mask, updated the cycle after.
`timescale 1ns/100ps
`include "status_filter_map.vh"
module scpi_status_event_filter (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // instrument activity levels
  input wire align_busy,
  input wire sweep_busy,
  input wire measure_busy,
  input wire trigger_wait,
  input wire measure_paused,
  // questionable summary levels
  input wire power_unleveled,
  input wire warming_up,
  input wire freq_unlocked,
  input wire align_fault,
  input wire integrity_fault,
  // command port
  input wire cmd_wr,
  input wire cmd_rd,
  input wire cmd_preset,
  input wire [3:0] cmd_sel,
  input wire [`STATUS_WIDTH-1:0] cmd_wdata,
  output reg [`STATUS_WIDTH-1:0] rsp_rdata,
  output reg rsp_valid,
  // status byte summaries and queue enable restore
  output wire operation_summary,
  output wire questionable_summary,
  output reg queue_enable_restore
);

  wire [`STATUS_WIDTH-1:0] op_raw;
  wire [`STATUS_WIDTH-1:0] qu_raw;
  wire [`STATUS_WIDTH-1:0] op_cond;
  wire [`STATUS_WIDTH-1:0] qu_cond;
  wire [`STATUS_WIDTH-1:0] op_event;
  wire [`STATUS_WIDTH-1:0] qu_event;
  wire [`STATUS_WIDTH-1:0] wvalue;
  wire op_read;
  wire qu_read;
  reg [`STATUS_WIDTH-1:0] operation_enable_mask_reg;
  reg [`STATUS_WIDTH-1:0] operation_falling_filter_reg;
  reg [`STATUS_WIDTH-1:0] operation_rising_filter_reg;
  reg [`STATUS_WIDTH-1:0] questionable_enable_mask_reg;
  reg [`STATUS_WIDTH-1:0] questionable_falling_filter_reg;
  reg [`STATUS_WIDTH-1:0] questionable_rising_filter_reg;
  reg [`STATUS_WIDTH-1:0] rdata_next;

  // next values of the programmable registers and of the answer
  wire wr_op_enable;
  wire wr_op_fall;
  wire wr_op_rise;
  wire wr_qu_enable;
  wire wr_qu_fall;
  wire wr_qu_rise;
  reg [`STATUS_WIDTH-1:0] operation_enable_mask_next;
  reg [`STATUS_WIDTH-1:0] operation_falling_filter_next;
  reg [`STATUS_WIDTH-1:0] operation_rising_filter_next;
  reg [`STATUS_WIDTH-1:0] questionable_enable_mask_next;
  reg [`STATUS_WIDTH-1:0] questionable_falling_filter_next;
  reg [`STATUS_WIDTH-1:0] questionable_rising_filter_next;
  reg [`STATUS_WIDTH-1:0] rsp_rdata_next;
  reg rsp_valid_next;
  reg queue_enable_restore_next;

  // each activity level lands on its own bit weight
  // positions without a level read as zero, so bit 15 never shows
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < `STATUS_WIDTH; bit_idx = bit_idx + 1) begin : g_cond_map
      assign op_raw[bit_idx] = ((bit_idx == `OP_BIT_ALIGN) && align_busy) // [R7]
        || ((bit_idx == `OP_BIT_SWEEP) && sweep_busy) // [R15]
        || ((bit_idx == `OP_BIT_MEASURE) && measure_busy)
        || ((bit_idx == `OP_BIT_TRIG_WAIT) && trigger_wait)
        || ((bit_idx == `OP_BIT_PAUSED) && measure_paused);
      assign qu_raw[bit_idx] = ((bit_idx == `QU_BIT_POWER) && power_unleveled) // [R16]
        || ((bit_idx == `QU_BIT_WARMUP) && warming_up)
        || ((bit_idx == `QU_BIT_FREQ) && freq_unlocked)
        || ((bit_idx == `QU_BIT_ALIGN_FAULT) && align_fault)
        || ((bit_idx == `QU_BIT_INTEGRITY) && integrity_fault);
    end
  endgenerate

  // condition pins come from other clock domains
  cond_sync #(.WIDTH(2 * `STATUS_WIDTH)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({qu_raw, op_raw}),
    .sync_out({qu_cond, op_cond})
  );

  assign op_read = cmd_rd && (cmd_sel == `SEL_OPERATION_EVENT); // [R4]
  assign qu_read = cmd_rd && (cmd_sel == `SEL_QUESTIONABLE_EVENT); // [R4]

  status_group u_operation (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cond(op_cond),
    .rise_filter(operation_rising_filter_reg),
    .fall_filter(operation_falling_filter_reg),
    .enable_mask(operation_enable_mask_reg),
    .event_read(op_read), // [R9]
    .event_reg(op_event),
    .summary_reg(operation_summary) // [R1]
  );

  status_group u_questionable (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cond(qu_cond),
    .rise_filter(questionable_rising_filter_reg),
    .fall_filter(questionable_falling_filter_reg),
    .enable_mask(questionable_enable_mask_reg),
    .event_read(qu_read),
    .event_reg(qu_event),
    .summary_reg(questionable_summary) // [R11]
  );

  // written values are bit-weight sums limited to 0..32767
  assign wvalue = cmd_wdata & `VALUE_MASK; // [R13] [R1]

  // one write strobe per register; condition, event and unmapped selects take no write
  assign wr_op_enable = cmd_wr && (cmd_sel == `SEL_OPERATION_ENABLE);
  assign wr_op_fall = cmd_wr && (cmd_sel == `SEL_OPERATION_FALL);
  assign wr_op_rise = cmd_wr && (cmd_sel == `SEL_OPERATION_RISE);
  assign wr_qu_enable = cmd_wr && (cmd_sel == `SEL_QUESTIONABLE_ENABLE);
  assign wr_qu_fall = cmd_wr && (cmd_sel == `SEL_QUESTIONABLE_FALL);
  assign wr_qu_rise = cmd_wr && (cmd_sel == `SEL_QUESTIONABLE_RISE);

  // preset wins over a write in the same cycle, so software cannot half-undo it
  // preset and reset share the defaults; the event latches never see the preset
  always @* begin
    operation_enable_mask_next = operation_enable_mask_reg;
    if (cmd_preset) begin
      operation_enable_mask_next = `RST_ENABLE; // [R2] [R8]
    end else if (wr_op_enable) begin
      operation_enable_mask_next = wvalue; // [R1] [R13]
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      operation_enable_mask_reg <= `RST_ENABLE; // [R2]
    end else begin
      operation_enable_mask_reg <= operation_enable_mask_next;
    end
  end

  always @* begin
    operation_falling_filter_next = operation_falling_filter_reg;
    if (cmd_preset) begin
      operation_falling_filter_next = `RST_FALL_FILTER; // [R5] [R8]
    end else if (wr_op_fall) begin
      operation_falling_filter_next = wvalue; // [R13]
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      operation_falling_filter_reg <= `RST_FALL_FILTER; // [R5]
    end else begin
      operation_falling_filter_reg <= operation_falling_filter_next;
    end
  end

  always @* begin
    operation_rising_filter_next = operation_rising_filter_reg;
    if (cmd_preset) begin
      operation_rising_filter_next = `RST_RISE_FILTER; // [R6] [R8]
    end else if (wr_op_rise) begin
      operation_rising_filter_next = wvalue; // [R13]
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      operation_rising_filter_reg <= `RST_RISE_FILTER; // [R6]
    end else begin
      operation_rising_filter_reg <= operation_rising_filter_next;
    end
  end

  always @* begin
    questionable_enable_mask_next = questionable_enable_mask_reg;
    if (cmd_preset) begin
      questionable_enable_mask_next = `RST_ENABLE; // [R12] [R8]
    end else if (wr_qu_enable) begin
      questionable_enable_mask_next = wvalue; // [R13]
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      questionable_enable_mask_reg <= `RST_ENABLE; // [R12]
    end else begin
      questionable_enable_mask_reg <= questionable_enable_mask_next;
    end
  end

  always @* begin
    questionable_falling_filter_next = questionable_falling_filter_reg;
    if (cmd_preset) begin
      questionable_falling_filter_next = `RST_FALL_FILTER; // [R8]
    end else if (wr_qu_fall) begin
      questionable_falling_filter_next = wvalue; // [R13]
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      questionable_falling_filter_reg <= `RST_FALL_FILTER;
    end else begin
      questionable_falling_filter_reg <= questionable_falling_filter_next;
    end
  end

  always @* begin
    questionable_rising_filter_next = questionable_rising_filter_reg;
    if (cmd_preset) begin
      questionable_rising_filter_next = `RST_RISE_FILTER; // [R8]
    end else if (wr_qu_rise) begin
      questionable_rising_filter_next = wvalue; // [R13]
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      questionable_rising_filter_reg <= `RST_RISE_FILTER;
    end else begin
      questionable_rising_filter_reg <= questionable_rising_filter_next;
    end
  end

  always @* begin
    case (cmd_sel)
      `SEL_OPERATION_COND: rdata_next = op_cond;
      `SEL_OPERATION_EVENT: rdata_next = op_event; // [R4]
      `SEL_OPERATION_ENABLE: rdata_next = operation_enable_mask_reg;
      `SEL_OPERATION_FALL: rdata_next = operation_falling_filter_reg;
      `SEL_OPERATION_RISE: rdata_next = operation_rising_filter_reg;
      `SEL_QUESTIONABLE_COND: rdata_next = qu_cond; // [R10]
      `SEL_QUESTIONABLE_EVENT: rdata_next = qu_event; // [R4]
      `SEL_QUESTIONABLE_ENABLE: rdata_next = questionable_enable_mask_reg;
      `SEL_QUESTIONABLE_FALL: rdata_next = questionable_falling_filter_reg;
      `SEL_QUESTIONABLE_RISE: rdata_next = questionable_rising_filter_reg;
      default: rdata_next = {`STATUS_WIDTH{1'b0}};
    endcase
  end

  // answer strobe stands one cycle; read data hold until the next read
  always @* begin
    rsp_valid_next = cmd_rd;
    rsp_rdata_next = rsp_rdata;
    if (cmd_rd) begin
      rsp_rdata_next = rdata_next; // [R13]
    end
    queue_enable_restore_next = cmd_preset; // [R8]
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= rsp_valid_next;
    end
  end

  // answers are whole integer sums of the selected bits
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rsp_rdata <= {`STATUS_WIDTH{1'b0}};
    end else begin
      rsp_rdata <= rsp_rdata_next;
    end
  end

  // the error queue keeps its own enable; it only hears that a preset happened
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      queue_enable_restore <= 1'b0;
    end else begin
      queue_enable_restore <= queue_enable_restore_next;
    end
  end

endmodule // scpi_status_event_filter

// file: tb/scpi_status_event_filter_properties.sv
`timescale 1ns/100ps
`include "status_filter_map.vh"
module status_filter_checker (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // command port
  input wire cmd_rd,
  input wire cmd_preset,
  input wire [`STATUS_WIDTH-1:0] rsp_rdata,
  input wire rsp_valid,
  // summaries
  input wire operation_summary,
  input wire questionable_summary,
  input wire queue_enable_restore
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_read_answer: assert property (cmd_rd |=> rsp_valid)
    else $error("read gave no answer");
  chk_answer_pulse: assert property (!cmd_rd |=> !rsp_valid)
    else $error("answer without read");
  chk_data_holds: assert property (!cmd_rd |=> $stable(rsp_rdata))
    else $error("read data moved without read");
  chk_read_range: assert property (rsp_valid |-> rsp_rdata[15] == 1'b0)
    else $error("read value above 32767");
  chk_preset_restore: assert property (cmd_preset |=> queue_enable_restore)
    else $error("no queue enable restore");
  chk_restore_pulse: assert property (!cmd_preset |=> !queue_enable_restore)
    else $error("restore without preset");
  chk_op_preset_mute: assert property (cmd_preset |-> ##2 !operation_summary)
    else $error("operation summary after preset");
  chk_qu_preset_mute: assert property (cmd_preset |-> ##2 !questionable_summary)
    else $error("questionable summary after preset");
  chk_reset_quiet: assert property ($fell(sys_rst) |-> !rsp_valid && rsp_rdata == 16'h0000
    && !operation_summary && !questionable_summary)
    else $error("outputs not clear after reset");
endmodule // status_filter_checker

bind scpi_status_event_filter status_filter_checker status_filter_checker_inst (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_rd(cmd_rd), .cmd_preset(cmd_preset),
  .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .operation_summary(operation_summary),
  .questionable_summary(questionable_summary), .queue_enable_restore(queue_enable_restore));

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  reg sys_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [4:0] op_in = 5'h00;
  reg [4:0] qu_in = 5'h00;
  reg cmd_wr = 1'b0;
  reg cmd_rd = 1'b0;
  reg cmd_preset = 1'b0;
  reg [3:0] cmd_sel = 4'h0;
  reg [15:0] cmd_wdata = 16'h0000;
  wire [15:0] rsp_rdata;
  wire rsp_valid, operation_summary, questionable_summary, queue_enable_restore;
  integer fail_count = 0;
  integer total_checks = 0;
  integer cycles = 0;
  always #10 sys_clk = ~sys_clk;
  scpi_status_event_filter scpi_status_event_filter_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .align_busy(op_in[0]), .sweep_busy(op_in[1]),
    .measure_busy(op_in[2]), .trigger_wait(op_in[3]), .measure_paused(op_in[4]),
    .power_unleveled(qu_in[0]), .warming_up(qu_in[1]), .freq_unlocked(qu_in[2]),
    .align_fault(qu_in[3]), .integrity_fault(qu_in[4]), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_preset(cmd_preset), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_rdata(rsp_rdata),
    .rsp_valid(rsp_valid), .operation_summary(operation_summary),
    .questionable_summary(questionable_summary), .queue_enable_restore(queue_enable_restore));
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task check16(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t value %h want %h", $time, got, exp);
      end
    end
  endtask
  task check1(input got, input exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t flag %b want %b", $time, got, exp);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  // strobes drop, then one spare cycle so a following access never re-raises in the same step
  task wr(input [3:0] s, input [15:0] d);
    begin
      cmd_wr = 1'b1;
      cmd_sel = s;
      cmd_wdata = d;
      idle(1);
      cmd_wr = 1'b0;
      idle(1);
    end
  endtask
  task rd_reg(input [3:0] s, input [15:0] exp);
    begin
      cmd_rd = 1'b1;
      cmd_sel = s;
      idle(1);
      cmd_rd = 1'b0;
      check1(rsp_valid, 1'b1);
      check16(rsp_rdata, exp);
      idle(1);
    end
  endtask
  task t_defaults;
    begin
      rd_reg(4'h2, 16'h0000);
      rd_reg(4'h3, 16'h0000);
      rd_reg(4'h4, 16'h7fff);
      rd_reg(4'h7, 16'h0000);
      rd_reg(4'hf, 16'h0000);
      rd_reg(4'h8, 16'h0000);
      rd_reg(4'h9, 16'h7fff);
    end
  endtask
  task t_rise;
    begin
      wr(4'h2, 16'h0001);
      op_in[0] = 1'b1;
      idle(5);
      check1(operation_summary, 1'b1);
      rd_reg(4'h0, 16'h0001);
      rd_reg(4'h1, 16'h0001);
      rd_reg(4'h1, 16'h0000);
      check1(operation_summary, 1'b0);
    end
  endtask
  task t_fall;
    begin
      wr(4'h3, 16'h0001);
      wr(4'h4, 16'h0000);
      op_in[0] = 1'b0;
      idle(5);
      rd_reg(4'h1, 16'h0001);
      op_in[0] = 1'b1;
      idle(5);
      rd_reg(4'h1, 16'h0000);
    end
  endtask
  task t_ques;
    begin
      wr(4'h7, 16'h0008);
      qu_in = 5'h01;
      idle(5);
      check1(questionable_summary, 1'b1);
      rd_reg(4'h5, 16'h0008);
      qu_in = 5'h1f;
      op_in = 5'h1f;
      idle(4);
      rd_reg(4'h5, 16'h0338);
      rd_reg(4'h0, 16'h0139);
      qu_in = 5'h00;
      wr(4'h5, 16'h00ff);
      idle(3);
      rd_reg(4'h5, 16'h0000);
      check1(questionable_summary, 1'b1);
    end
  endtask
  task t_preset;
    begin
      wr(4'h8, 16'h0200);
      wr(4'h9, 16'h0000);
      wr(4'h2, 16'hffff);
      rd_reg(4'h2, 16'h7fff);
      cmd_preset = 1'b1;
      idle(1);
      cmd_preset = 1'b0;
      check1(queue_enable_restore, 1'b1);
      idle(1);
      rd_reg(4'h2, 16'h0000);
      rd_reg(4'h3, 16'h0000);
      rd_reg(4'h4, 16'h7fff);
      rd_reg(4'h7, 16'h0000);
      rd_reg(4'h8, 16'h0000);
      rd_reg(4'h9, 16'h7fff);
      check1(questionable_summary, 1'b0);
      rd_reg(4'h6, 16'h0338);
    end
  endtask
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end
  initial begin
    idle(12);
    sys_rst = 1'b0;
    t_defaults;
    t_rise;
    t_fall;
    t_ques;
    t_preset;
    end_of_test;
  end
endmodule // testbench
